/* File: rtl/ccfs_status.sv */
// Purpose: Two sticky write-1-to-clear fault status registers
// Assumes: Event inputs are synchronous one-cycle or level signals
// Notes: Pin-short and thermal inputs are live conditions
//
// Functional notes
// - CRC mismatch latches bit 4 until cleared
// - CRC flag reads 0 when disabled
// - Interrupt pin short sets bit 3 always
// - Pin flag clears only after fault removed
// - Thermal flag gated, clears after condition ends
// - Sync short sets bit 1, conditional clear
// - Sync flag reads 0 when disabled
// - Packet error latches bit 0, W1C
// - Single error corrected sets test bit 3
// - Double error sets test bit 2 always
// - Self-test completion sets test bit 1
// - Self-test fault latches test bit 0
`default_nettype none

module ccfs_status (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire ccfs_pkg::ccfs_event_t events,
  input wire ccfs_pkg::ccfs_enable_t enables
);

  // ************************************************************
  // Status storage
  // ************************************************************
  logic [4:0] ctrl_flags;
  logic [4:0] next_ctrl_flags;
  logic [3:0] test_flags;
  logic [3:0] next_test_flags;
  logic [7:0] next_reg_rdata;
  logic [4:0] ctrl_set;
  logic [4:0] ctrl_hold;
  logic [3:0] test_set;
  logic [4:0] ctrl_vis;
  logic [3:0] test_vis;
  logic ctrl_wr;
  logic test_wr;
  logic [4:0] ctrl_allow;
  logic [3:0] test_allow;
  logic [7:0] ctrl_upd;
  logic [7:0] test_upd;

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Address match for the control fault register
  function automatic logic is_ctrl_addr(
    input logic [7:0] addr
  );
    return addr == ccfs_pkg::CTRL_STATUS_OFS;
  endfunction : is_ctrl_addr

  // Address match for the test fault register
  function automatic logic is_test_addr(
    input logic [7:0] addr
  );
    return addr == ccfs_pkg::TEST_STATUS_OFS;
  endfunction : is_test_addr

  // Control bits that may set and show; pin and packet always on
  function automatic logic [4:0] ctrl_gate(
    input ccfs_pkg::ccfs_enable_t en
  );
    logic [4:0] allow;
    allow = 5'h1f;
    allow[ccfs_pkg::CRC_BIT] = en.runtime_checksum_enable;
    allow[ccfs_pkg::TSD_BIT] = en.thermal_enable;
    allow[ccfs_pkg::SYNC_BIT] = en.sync_enable;
    return allow;
  endfunction : ctrl_gate

  // Test bits that may set and show; double error always on
  function automatic logic [3:0] test_gate(
    input ccfs_pkg::ccfs_enable_t en
  );
    logic [3:0] allow;
    allow = 4'hf;
    allow[ccfs_pkg::SEC_BIT] = en.sec_enable;
    allow[ccfs_pkg::DONE_BIT] = en.selftest_done_enable;
    allow[ccfs_pkg::BIST_BIT] = en.selftest_fault_enable;
    return allow;
  endfunction : test_gate

  // Sticky update: ones clear unless held, set wins over clear
  function automatic logic [7:0] sticky_next(
    input logic [7:0] flags,
    input logic [7:0] clear,
    input logic [7:0] hold,
    input logic [7:0] raise
  );
    return (flags & ~(clear & ~hold)) | raise;
  endfunction : sticky_next

  // ************************************************************
  // Write decode and enable masks
  // ************************************************************

  // Write strobes for each register
  assign ctrl_wr = reg_write && is_ctrl_addr(reg_addr);
  assign test_wr = reg_write && is_test_addr(reg_addr);

  // Enable masks shared by the set and read paths
  assign ctrl_allow = ctrl_gate(enables);
  assign test_allow = test_gate(enables);

  // ************************************************************
  // Set and hold terms
  // ************************************************************

  // Raw set terms, then enable gating at the source
  always_comb
  begin
    ctrl_set = 5'h00;
    ctrl_set[ccfs_pkg::CRC_BIT] = events.crc_mismatch;
    ctrl_set[ccfs_pkg::IRQ_PIN_BIT] = events.irq_pin_short;
    ctrl_set[ccfs_pkg::TSD_BIT] = events.thermal_shutdown;
    ctrl_set[ccfs_pkg::SYNC_BIT] = events.sync_pin_short;
    ctrl_set[ccfs_pkg::PEC_BIT] = events.packet_error;
    ctrl_set = ctrl_set & ctrl_allow;
    test_set = 4'h0;
    test_set[ccfs_pkg::SEC_BIT] = events.single_error_corrected;
    test_set[ccfs_pkg::DED_BIT] = events.double_error_detected;
    test_set[ccfs_pkg::DONE_BIT] = events.selftest_done;
    test_set[ccfs_pkg::BIST_BIT] = events.selftest_fault;
    test_set = test_set & test_allow;
  end

  // Live conditions that block a clear while present
  always_comb
  begin
    ctrl_hold = '0;
    ctrl_hold[ccfs_pkg::IRQ_PIN_BIT] = events.irq_pin_short;
    ctrl_hold[ccfs_pkg::TSD_BIT] = events.thermal_shutdown;
    ctrl_hold[ccfs_pkg::SYNC_BIT] = events.sync_pin_short;
  end

  // ************************************************************
  // Next flag values
  // ************************************************************

  // Control flags: zeros ignored, live conditions block a clear
  always_comb
  begin
    ctrl_upd = sticky_next({3'h0, ctrl_flags},
      ctrl_wr ? reg_wdata : 8'h00, {3'h0, ctrl_hold},
      {3'h0, ctrl_set});
    next_ctrl_flags = ctrl_upd[4:0];
  end

  // Test flags: zeros ignored, nothing blocks a clear
  always_comb
  begin
    test_upd = sticky_next({4'h0, test_flags},
      test_wr ? reg_wdata : 8'h00, 8'h00,
      {4'h0, test_set});
    next_test_flags = test_upd[3:0];
  end

  // ************************************************************
  // Read path
  // ************************************************************

  // Visible flags read 0 while their enable is off
  always_comb
  begin
    ctrl_vis = ctrl_flags & ctrl_allow;
    test_vis = test_flags & test_allow;
  end

  // Read data mux, reserved bits and other addresses zero
  always_comb
  begin
    if (is_ctrl_addr(reg_addr))
    begin
      next_reg_rdata = {3'h0, ctrl_vis};
    end
    else if (is_test_addr(reg_addr))
    begin
      next_reg_rdata = {4'h0, test_vis};
    end
    else
    begin
      next_reg_rdata = 8'h00;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************

  // Control fault flags
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_flags <= ccfs_pkg::CTRL_RESET;
    end
    else
    begin
      ctrl_flags <= next_ctrl_flags;
    end
  end

  // Test fault flags
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      test_flags <= ccfs_pkg::TEST_RESET;
    end
    else
    begin
      test_flags <= next_test_flags;
    end
  end

  // Registered read data, one cycle behind the address
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule : ccfs_status

`default_nettype wire

/* File: rtl/ccfs_pkg.sv */
// Purpose: Shared constants and types for the fault status block
// Assumes: 8-bit register port, byte offsets as printed
// Notes: Reserved bits read as zero
`default_nettype none

package ccfs_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] CTRL_STATUS_OFS = 8'h22;
  localparam logic [7:0] TEST_STATUS_OFS = 8'h23;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CRC_BIT = 4;
  localparam int IRQ_PIN_BIT = 3;
  localparam int TSD_BIT = 2;
  localparam int SYNC_BIT = 1;
  localparam int PEC_BIT = 0;
  localparam int SEC_BIT = 3;
  localparam int DED_BIT = 2;
  localparam int DONE_BIT = 1;
  localparam int BIST_BIT = 0;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [3:0] TEST_RESET = 4'h0;

  // Fault events and live conditions from the rest of the device
  typedef struct packed {
    logic crc_mismatch;
    logic irq_pin_short;
    logic thermal_shutdown;
    logic sync_pin_short;
    logic packet_error;
    logic single_error_corrected;
    logic double_error_detected;
    logic selftest_done;
    logic selftest_fault;
  } ccfs_event_t;

  // Enables from the interrupt-enable registers
  typedef struct packed {
    logic runtime_checksum_enable;
    logic thermal_enable;
    logic sync_enable;
    logic sec_enable;
    logic selftest_done_enable;
    logic selftest_fault_enable;
  } ccfs_enable_t;

endpackage : ccfs_pkg

`default_nettype wire

/* File: verification/ccfs_host.sv */
// Purpose: Host model for the status registers
// Assumes: Random word from the bench
// Notes: Writes back read ones or noise
`default_nettype none
module ccfs_host (
  input wire logic clock,
  input wire logic [31:0] rnd,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic write,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Register pick and write strobe
  always @(posedge clock)
  begin
    addr <= rnd[1] & rnd[4] ? 8'h5a : {7'h11, rnd[0]};
    write <= rnd[2];
    wdata <= rnd[3] ? rdata : rnd[15:8];
  end
endmodule : ccfs_host
`default_nettype wire

/* File: verification/ccfs_monitor.sv */
// Purpose: Port checker for the status block
// Assumes: Read data lags address by one edge
// Notes: Bound into ccfs_status
`default_nettype none
module ccfs_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire ccfs_pkg::ccfs_event_t events,
  input wire ccfs_pkg::ccfs_enable_t enables
);
  timeunit 1ns;
  timeprecision 1ns;
  // Address decodes
  wire logic c = reg_addr == 8'h22;
  wire logic t = reg_addr == 8'h23;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_crc_masked:
  assert property (c && !enables.runtime_checksum_enable |=> !reg_rdata[4])
    else $error("crc");
  a_tsd_masked:
  assert property (c && !enables.thermal_enable |=> !reg_rdata[2])
    else $error("tsd");
  a_sync_masked:
  assert property (c && !enables.sync_enable |=> !reg_rdata[1])
    else $error("sync");
  a_pin_sets:
  assert property (events.irq_pin_short && c ##1 c |=> reg_rdata[3])
    else $error("pin set");
  a_pin_clears:
  assert property (reg_write && c && reg_wdata[3] && !events.irq_pin_short
    ##1 c |=> !reg_rdata[3]) else $error("pin clear");
  a_pec_clears:
  assert property (reg_write && c && reg_wdata[0] && !events.packet_error
    ##1 c |=> !reg_rdata[0]) else $error("pec clear");
  a_ded_sets:
  assert property (events.double_error_detected && t ##1 t |=> reg_rdata[2])
    else $error("ded");
  a_rsvd_zero:
  assert property (t |=> reg_rdata[7:4] == 4'h0) else $error("rsvd");
endmodule : ccfs_monitor
bind ccfs_status ccfs_monitor ccfs_monitor_i (.clock(clock), .resetn(resetn),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .events(events), .enables(enables));
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Random bench with flag mirror
// Assumes: Seed 92
// Notes: Held-fault and clear corners, then a mid-run reset
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock;
  logic resetn;
  logic write;
  logic [31:0] r = 32'h5c;
  logic [7:0] addr, wdata, rdata, exp;
  logic [8:0] s;
  ccfs_pkg::ccfs_event_t ev;
  ccfs_pkg::ccfs_enable_t en;
  int n_mismatch = 0;
  int cmp_count = 0;
  wire logic [8:0] cm = !write ? 9'h0 : addr == 8'h22 ? {wdata[4:0], 4'h0}
    : addr == 8'h23 ? {5'h0, wdata[3:0]} : 9'h0;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  function automatic logic [8:0] msk(input ccfs_pkg::ccfs_enable_t e);
    return {e[5], 1'b1, e[4:3], 1'b1, e[2], 1'b1, e[1:0]};
  endfunction : msk
  // Enable mask of the flags that may set and show
  wire logic [8:0] vm = msk(en);
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("mismatch at %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  ccfs_status ccfs_status_i (.clock(clock), .resetn(resetn), .reg_addr(addr),
    .reg_write(write), .reg_wdata(wdata), .reg_rdata(rdata), .events(ev),
    .enables(en));
  ccfs_host ccfs_host_i (.clock(clock), .rnd(r), .rdata(rdata), .addr(addr),
    .write(write), .wdata(wdata));
  // Mirror of flags and read data
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      {s, exp} <= 17'h0;
    else
    begin
      if (addr == 8'h22)
        exp <= {3'h0, s[8:4] & vm[8:4]};
      else if (addr == 8'h23)
        exp <= {4'h0, s[3:0] & vm[3:0]};
      else
        exp <= 8'h00;
      s <= (ev & msk(en)) | (s & ~(cm & ~{1'b0, ev[7:5], 5'h0}));
    end
  end
  always @(negedge clock)
    check(rdata, exp);
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test;
  end
  initial
  begin
    resetn = 1'b0;
    {ev, en} = 15'h0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (8) @(posedge clock)
    begin
      r <= 32'hfffffffc;
      {ev, en} <= 15'h7fff;
    end
    $display("test corner done");
    repeat (6) @(posedge clock)
    begin
      r <= {16'h0, 8'hff, 7'h02, ~r[0]};
      ev <= 9'h000;
    end
    $display("test clear done");
    repeat (3000) @(posedge clock)
    begin
      r <= xs(r);
      ev <= r[8:0] & r[17:9] & r[26:18];
      en <= r[31:26] | r[5:0];
    end
    $display("test random done");
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (500) @(posedge clock)
    begin
      r <= xs(r);
      ev <= r[8:0] & r[17:9] & r[26:18];
      en <= r[31:26] | r[5:0];
    end
    $display("test reset done");
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
